// file: hw/sef_params.svh
// Constants for the serial memory front end: status layout and opcodes
`ifndef SEF_PARAMS_SVH
`define SEF_PARAMS_SVH

// Status byte bit positions
`define SEF_ST_BUSY      0
`define SEF_ST_WEL       1
`define SEF_ST_BP_LO     2
`define SEF_ST_BP_HI     3
`define SEF_ST_RFU_LSB   4
`define SEF_ST_RFU_MSB   7
`define SEF_RFU_IDLE     4'h0
`define SEF_RFU_BUSY     4'hF

// Opcode byte layout: upper nibble zero, bit 3 free, bits 2:0 select
`define SEF_OPC_HI_MSB   7
`define SEF_OPC_HI_LSB   4
`define SEF_OPC_HI_VAL   4'h0
`define SEF_OPC_FREE_BIT 3
`define SEF_OPC_WEN      3'h6
`define SEF_OPC_WDI      3'h4
`define SEF_OPC_SRD      3'h5
`define SEF_OPC_SWR      3'h1
`define SEF_OPC_ARD      3'h3
`define SEF_OPC_AWR      3'h2

// Reset values and the last bit count
`define SEF_WEL_RST      1'b0
`define SEF_BIT_LAST     3'h7
`define SEF_BIT_RST      3'h0
`define SEF_BYTE_RST     8'h00

`endif

// file: hw/sef_pkg.sv
// Types shared by the serial memory front end
package sef_pkg;

    typedef enum logic [2:0] {
        SEF_OP_NONE = 3'h0,
        SEF_OP_WEN  = 3'h1,
        SEF_OP_WDI  = 3'h2,
        SEF_OP_SRD  = 3'h3,
        SEF_OP_SWR  = 3'h4,
        SEF_OP_ARD  = 3'h5,
        SEF_OP_AWR  = 3'h6,
        SEF_OP_BAD  = 3'h7
    } sef_op_t;

    typedef enum logic [2:0] {
        SEF_ST_IDLE   = 3'h0,
        SEF_ST_OPCODE = 3'h1,
        SEF_ST_ADDR   = 3'h2,
        SEF_ST_DIN    = 3'h3,
        SEF_ST_DOUT   = 3'h4,
        SEF_ST_DONE   = 3'h5,
        SEF_ST_IGNORE = 3'h6
    } sef_state_t;

endpackage

// file: hw/sef_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module sef_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    // Reset to all ones: the select, hold and protect pins synchronised here idle high
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            meta_reg <= '1;
            q        <= '1;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// file: hw/sef_opdec.sv
// Opcode byte decoder
`timescale 1ns/1ps
`include "sef_params.svh"
`default_nettype none

module sef_opdec (
    input  wire logic [7:0]      op_byte,
    output var  sef_pkg::sef_op_t op_kind,
    output var  logic            addr_msb
);
    import sef_pkg::*;

    // Bit 3 is the address top bit for array ops, don't-care otherwise
    always_comb
    begin
        addr_msb = op_byte[`SEF_OPC_FREE_BIT];
        op_kind  = SEF_OP_BAD;
        if (op_byte[`SEF_OPC_HI_MSB:`SEF_OPC_HI_LSB] == `SEF_OPC_HI_VAL)
        begin
            case (op_byte[2:0])
                `SEF_OPC_WEN: op_kind = SEF_OP_WEN;
                `SEF_OPC_WDI: op_kind = SEF_OP_WDI;
                `SEF_OPC_SRD: op_kind = SEF_OP_SRD;
                `SEF_OPC_SWR: op_kind = SEF_OP_SWR;
                `SEF_OPC_ARD: op_kind = SEF_OP_ARD;
                `SEF_OPC_AWR: op_kind = SEF_OP_AWR;
                default:      op_kind = SEF_OP_BAD;
            endcase
        end
    end

endmodule

`default_nettype wire

// file: hw/sef_front.sv
// Serial front end of a small SPI nonvolatile memory
`timescale 1ns/1ps
`include "sef_params.svh"
`default_nettype none

// What this block does
// - Ignore all instructions while power-on reset holds
// - Power up deselected, unheld, latch and busy clear
// - Block protect bits kept across power cycles
// - Factory state: array FFh, protect bits zero
// - Select toggle without clocks resets the interface
// - Modes 0 and 3: sample rising, launch falling
// - Deselected: ignore input, output high impedance
// - Shift in MSB first from first rise
// - Reads shift out MSB first from next fall
// - First byte after select is the opcode
// - Bad opcode: ignore input, tristate until reselect
// - Hold never pauses a running write cycle
// - Enter hold at clock low with hold_n low
// - Leave hold at clock low with hold_n high
// - In hold: tristate, ignore input and clock
// - Deselect during hold aborts and clears latch
// - Protect pin low blocks every write
// - Protect falling while selected cancels pending write
// - Decode the six opcode formats
// - Status: busy, latch, protect, upper nibble busy
// - Write enable sets latch at deselect, protect high
// - Write disable clears latch regardless of protect
module sef_front (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             cs_n_pin,
    input  wire logic             sck_pin,
    input  wire logic             si_pin,
    input  wire logic             hold_n_pin,
    input  wire logic             write_protect_n_pin,
    output var  logic             so_out,
    output var  logic             so_oe_n,
    input  wire logic             write_busy,
    input  wire logic             write_done,
    input  wire logic             block_protect_hi,
    input  wire logic             block_protect_lo,
    input  wire logic [7:0]       array_rd_data,
    output var  sef_pkg::sef_op_t opcode_out,
    output var  logic             opcode_strobe,
    output var  logic [8:0]       addr_out,
    output var  logic             addr_strobe,
    output var  logic [7:0]       rx_data,
    output var  logic             rx_strobe,
    output var  logic             rd_next,
    output var  logic             write_start,
    output var  logic             write_abort,
    output var  logic             write_enable_latch,
    output var  logic             hold_active
);
    import sef_pkg::*;

    logic [4:0]  pin_raw;
    logic [4:0]  pin_s;
    logic        sel;
    logic        sck_s;
    logic        si_s;
    logic        hold_n_s;
    logic        wp_n_s;
    logic        sck_prev_reg;
    logic        sel_prev_reg;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_fall;
    logic        cs_rise;
    sef_state_t  state_reg;
    sef_op_t     op_reg;
    sef_op_t     dec_op;
    logic        dec_msb;
    logic        addr_msb_reg;
    logic [2:0]  bit_cnt_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  full_byte;
    logic        byte_done;
    logic        shifting;
    logic        data_seen_reg;
    logic [7:0]  tx_shift_reg;
    logic [2:0]  out_cnt_reg;
    logic        out_started_reg;
    logic [7:0]  status_byte;
    logic [7:0]  tx_byte;
    logic        wp_cancel_reg;
    logic        wel_set;
    logic        wel_clr;
    logic        commit;

    // Every pin is asynchronous to core_clk; the link clock is sampled
    assign pin_raw = {write_protect_n_pin, hold_n_pin, si_pin, sck_pin,
                      cs_n_pin};

    sef_sync #(
        .WIDTH (5)
    ) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .d        (pin_raw),
        .q        (pin_s)
    );

    assign sel      = ~pin_s[0];
    assign sck_s    = pin_s[1];
    assign si_s     = pin_s[2];
    assign hold_n_s = pin_s[3];
    assign wp_n_s   = pin_s[4];

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            // Same level as the synchroniser reset, so no false edge
            sck_prev_reg <= 1'b1;
            sel_prev_reg <= 1'b0;
        end
        else
        begin
            sck_prev_reg <= sck_s;
            sel_prev_reg <= sel;
        end
    end

    // Clock edges count only while selected and not held
    assign sck_rise = sck_s & ~sck_prev_reg & sel & ~hold_active;
    assign sck_fall = ~sck_s & sck_prev_reg & sel & ~hold_active;
    assign cs_fall  = sel & ~sel_prev_reg;
    assign cs_rise  = ~sel & sel_prev_reg;

    // Hold state follows hold_n only while the clock is low; deselect clears it at once
    always_ff @(posedge core_clk)
    begin
        if (reset || !sel)
            hold_active <= 1'b0;
        else if (!sck_s)
            hold_active <= ~hold_n_s;
    end

    sef_opdec u_opdec (
        .op_byte  (full_byte),
        .op_kind  (dec_op),
        .addr_msb (dec_msb)
    );

    assign shifting  = sck_rise && (state_reg == SEF_ST_OPCODE ||
                       state_reg == SEF_ST_ADDR || state_reg == SEF_ST_DIN);
    assign full_byte = {shift_reg[6:0], si_s};
    assign byte_done = shifting && (bit_cnt_reg == `SEF_BIT_LAST);

    // Input shifter; DONE and IGNORE take no more bits
    always_ff @(posedge core_clk)
    begin
        if (reset || cs_fall)
        begin
            bit_cnt_reg <= `SEF_BIT_RST;
            shift_reg   <= `SEF_BYTE_RST;
        end
        else if (shifting)
        begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg   <= full_byte;
        end
    end

    // Sequence; a new selection always restarts at the opcode byte
    always_ff @(posedge core_clk)
    begin
        if (reset)
            state_reg <= SEF_ST_IDLE;
        else if (cs_fall)
            state_reg <= SEF_ST_OPCODE;
        else if (cs_rise)
            state_reg <= SEF_ST_IDLE;
        else if (byte_done)
        begin
            case (state_reg)
                SEF_ST_OPCODE:
                begin
                    // While a write cycle runs only status reads get through
                    if (dec_op == SEF_OP_BAD)
                        state_reg <= SEF_ST_IGNORE;
                    else if (write_busy && dec_op != SEF_OP_SRD)
                        state_reg <= SEF_ST_IGNORE;
                    else if (dec_op == SEF_OP_SRD)
                        state_reg <= SEF_ST_DOUT;
                    else if (dec_op == SEF_OP_SWR)
                        state_reg <= SEF_ST_DIN;
                    else if (dec_op == SEF_OP_ARD || dec_op == SEF_OP_AWR)
                        state_reg <= SEF_ST_ADDR;
                    else
                        state_reg <= SEF_ST_DONE;
                end
                SEF_ST_ADDR:
                    state_reg <= (op_reg == SEF_OP_ARD) ? SEF_ST_DOUT
                                                        : SEF_ST_DIN;
                default:
                    state_reg <= state_reg;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset || cs_fall)
        begin
            op_reg       <= SEF_OP_NONE;
            addr_msb_reg <= 1'b0;
        end
        else if (byte_done && state_reg == SEF_ST_OPCODE)
        begin
            op_reg       <= dec_op;
            addr_msb_reg <= dec_msb;
        end
    end

    // Byte strobes towards the array sequencer
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            opcode_out    <= SEF_OP_NONE;
            opcode_strobe <= 1'b0;
            addr_out      <= 9'h000;
            addr_strobe   <= 1'b0;
            rx_data       <= `SEF_BYTE_RST;
            rx_strobe     <= 1'b0;
        end
        else
        begin
            opcode_strobe <= byte_done && state_reg == SEF_ST_OPCODE &&
                             dec_op != SEF_OP_BAD;
            addr_strobe   <= byte_done && state_reg == SEF_ST_ADDR;
            rx_strobe     <= byte_done && state_reg == SEF_ST_DIN;
            if (byte_done && state_reg == SEF_ST_OPCODE)
                opcode_out <= dec_op;
            if (byte_done && state_reg == SEF_ST_ADDR)
                addr_out <= {addr_msb_reg, full_byte};
            if (byte_done && state_reg == SEF_ST_DIN)
                rx_data <= full_byte;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset || cs_fall)
            data_seen_reg <= 1'b0;
        else if (byte_done && state_reg == SEF_ST_DIN)
            data_seen_reg <= 1'b1;
    end

    // Protect bits come from nonvolatile cells outside and are never reset
    assign status_byte = {write_busy ? `SEF_RFU_BUSY : `SEF_RFU_IDLE,
                          block_protect_hi, block_protect_lo,
                          write_enable_latch, write_busy};
    assign tx_byte = (op_reg == SEF_OP_SRD) ? status_byte : array_rd_data;

    // Output shifter: a fresh byte every eight falling edges
    always_ff @(posedge core_clk)
    begin
        if (reset || cs_fall)
        begin
            so_out          <= 1'b0;
            tx_shift_reg    <= `SEF_BYTE_RST;
            out_cnt_reg     <= `SEF_BIT_RST;
            out_started_reg <= 1'b0;
        end
        else if (sck_fall && state_reg == SEF_ST_DOUT)
        begin
            if (out_cnt_reg == `SEF_BIT_RST)
            begin
                so_out       <= tx_byte[7];
                tx_shift_reg <= {tx_byte[6:0], 1'b0};
            end
            else
            begin
                so_out       <= tx_shift_reg[7];
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
            out_cnt_reg     <= out_cnt_reg + 3'h1;
            out_started_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            rd_next <= 1'b0;
        else
            rd_next <= sck_fall && state_reg == SEF_ST_DOUT &&
                       op_reg == SEF_OP_ARD && out_cnt_reg == `SEF_BIT_LAST;
    end

    // Drive only during a read phase, selected and not held
    assign so_oe_n = ~(state_reg == SEF_ST_DOUT && out_started_reg && sel &&
                       ~hold_active);

    // Protect pin falling during a selection kills that selection's write
    always_ff @(posedge core_clk)
    begin
        if (reset || cs_fall)
            wp_cancel_reg <= 1'b0;
        else if (sel && !wp_n_s)
            wp_cancel_reg <= 1'b1;
    end

    assign wel_set = cs_rise && hold_n_s && state_reg == SEF_ST_DONE &&
                     op_reg == SEF_OP_WEN && wp_n_s && !wp_cancel_reg;
    assign wel_clr = (cs_rise && !hold_n_s) ||
                     (cs_rise && state_reg == SEF_ST_DONE &&
                      op_reg == SEF_OP_WDI) ||
                     write_done;

    // A set in the same cycle as the end-of-write clear wins
    always_ff @(posedge core_clk)
    begin
        if (reset)
            write_enable_latch <= `SEF_WEL_RST;
        else if (wel_set)
            write_enable_latch <= 1'b1;
        else if (wel_clr)
            write_enable_latch <= 1'b0;
    end

    assign commit = cs_rise && hold_n_s && state_reg == SEF_ST_DIN &&
                    data_seen_reg && write_enable_latch && wp_n_s &&
                    !wp_cancel_reg && !write_busy &&
                    (op_reg == SEF_OP_AWR || op_reg == SEF_OP_SWR);

    // Abort never reaches a running cycle, which completes on its own
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            write_start <= 1'b0;
            write_abort <= 1'b0;
        end
        else
        begin
            write_start <= commit;
            write_abort <= cs_rise && !hold_n_s &&
                           state_reg != SEF_ST_IDLE && !write_busy;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    reset_state_a: assert property (disable iff (1'b0)
        reset |=> state_reg == SEF_ST_IDLE && !write_enable_latch && so_oe_n)
        else $error("state not cleared by reset");
    hold_tristate_a: assert property (hold_active |-> so_oe_n)
        else $error("output driven during hold");
    desel_tristate_a: assert property (!sel |-> so_oe_n)
        else $error("output driven while deselected");
    bad_op_quiet_a: assert property (
        state_reg == SEF_ST_IGNORE && sel && !cs_fall
        |=> (state_reg == SEF_ST_IGNORE && so_oe_n) || !sel)
        else $error("invalid opcode did not silence the device");
    hold_freeze_a: assert property (
        hold_active && sel |=> $stable(bit_cnt_reg) && $stable(shift_reg) &&
                        $stable(state_reg))
        else $error("shifter moved during hold");
    wel_set_a: assert property (wel_set |=> write_enable_latch)
        else $error("write enable did not set latch");
    wel_clear_a: assert property (
        cs_rise && state_reg == SEF_ST_DONE && op_reg == SEF_OP_WDI
        |=> !write_enable_latch)
        else $error("write disable did not clear latch");
    hold_abort_a: assert property (
        cs_rise && !hold_n_s |=> !write_enable_latch && !write_start)
        else $error("deselect in hold did not abort");
    wp_block_a: assert property (write_start |-> $past(wp_n_s))
        else $error("write started with protect pin low");
    shift_msb_a: assert property (
        shifting |=> shift_reg[0] == $past(si_s) &&
                     shift_reg[7:1] == $past(shift_reg[6:0]))
        else $error("input not shifted msb first");

endmodule

`default_nettype wire

// file: dv/sef_spi_master.sv
// Behavioural SPI master that drives the memory front end pins
`timescale 1ns/1ps
`default_nettype none

module sef_spi_master (
    input  wire logic core_clk,
    input  wire logic so_out,
    output var  logic cs_n,
    output var  logic sck,
    output var  logic si
);
    localparam int HALF = 8;
    logic mode3;

    initial
    begin
        mode3 = 1'b0;
        cs_n  = 1'b1;
        sck   = 1'b0;
        si    = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic sel();
        sck = mode3;
        tick(16);
        cs_n = 1'b0;
        tick(16);
    endtask

    // A released data line must not keep showing the last bit
    task automatic desel();
        tick(16);
        cs_n = 1'b1;
        si   = ~si;
        tick(16);
    endtask

    // Mode 3 idles high, so each bit opens with a fall there
    task automatic xfer(input int n, input logic [7:0] tx,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++)
        begin
            sck = 1'b0;
            si  = tx[7-i];
            tick(HALF);
            rx  = {rx[6:0], so_out};
            sck = 1'b1;
            tick(HALF);
        end
        if (!mode3)
        begin
            sck = 1'b0;
            tick(HALF);
        end
    endtask
endmodule
`default_nettype wire

// file: dv/spi_eeprom_slave_front_end_tb_top.sv
// Self-checking bench for the serial memory front end
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_slave_front_end_tb_top;
    import sef_pkg::*;

    logic       core_clk;
    logic       reset;
    logic       cs_n;
    logic       sck;
    logic       si;
    logic       hold_n;
    logic       wp_n;
    logic       so_out;
    logic       so_oe_n;
    logic       write_busy;
    logic       write_done;
    logic       bp_hi;
    logic       bp_lo;
    logic [7:0] rd_data;
    sef_op_t    opcode_out;
    logic       opcode_strobe;
    logic [8:0] addr_out;
    logic       addr_strobe;
    logic [7:0] rx_data;
    logic       rx_strobe;
    logic       rd_next;
    logic       write_start;
    logic       write_abort;
    logic       latch;
    logic       hold_active;
    int         num_errors = 0;
    int         checks = 0;
    int         seed = 32'hBBA5;
    int         exp_ws = 0;
    int         aborts = 0;
    int         rd_nexts = 0;
    logic [2:0] r;
    logic       lat = 1'b0;
    sef_op_t    e_op;
    logic [8:0] e_w;
    logic [7:0] junk;
    logic [7:0] d;
    sef_op_t    exp_op[$];
    logic [8:0] exp_addr[$];
    logic [7:0] exp_rx[$];
    localparam logic [7:0] CTAB [5] = '{8'h0E, 8'h04, 8'h06, 8'h06, 8'h0C};
    localparam logic       WTAB [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    localparam logic [7:0] BAD [3] = '{8'h15, 8'h07, 8'h08};

    sef_front sef_front_inst (
        .core_clk(core_clk), .reset(reset), .cs_n_pin(cs_n),
        .sck_pin(sck), .si_pin(si), .hold_n_pin(hold_n),
        .write_protect_n_pin(wp_n), .so_out(so_out), .so_oe_n(so_oe_n),
        .write_busy(write_busy), .write_done(write_done),
        .block_protect_hi(bp_hi), .block_protect_lo(bp_lo),
        .array_rd_data(rd_data), .opcode_out(opcode_out),
        .opcode_strobe(opcode_strobe), .addr_out(addr_out),
        .addr_strobe(addr_strobe), .rx_data(rx_data),
        .rx_strobe(rx_strobe), .rd_next(rd_next),
        .write_start(write_start), .write_abort(write_abort),
        .write_enable_latch(latch), .hold_active(hold_active)
    );

    sef_spi_master sef_spi_master_inst (
        .core_clk(core_clk), .so_out(so_out), .cs_n(cs_n),
        .sck(sck), .si(si)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic report(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic cmp_op(input sef_op_t got, input sef_op_t exp);
        report({6'h00, got}, {6'h00, exp});
    endtask

    task automatic cmp_word(input logic [8:0] got, input logic [8:0] exp);
        report(got, exp);
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        report({8'h00, got}, {8'h00, exp});
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Strobes are registered, so sample them away from the active edge
    always @(negedge core_clk)
    begin
        if (opcode_strobe === 1'b1)
        begin
            e_op = exp_op.size() ? exp_op.pop_front() : SEF_OP_BAD;
            cmp_op(opcode_out, e_op);
        end
        if (addr_strobe === 1'b1)
        begin
            e_w = exp_addr.size() ? exp_addr.pop_front() : 'x;
            cmp_word(addr_out, e_w);
        end
        if (rx_strobe === 1'b1)
        begin
            e_w = exp_rx.size() ? {1'b0, exp_rx.pop_front()} : 'x;
            cmp_word({1'b0, rx_data}, e_w);
        end
        if (rd_next === 1'b1)
            rd_nexts++;
        if (write_start === 1'b1)
        begin
            cmp_bit(1'b1, exp_ws > 0);
            exp_ws--;
        end
        if (write_abort === 1'b1)
            aborts++;
    end

    function automatic logic [7:0] st(input logic lat, input logic busy);
        return {busy ? 4'hF : 4'h0, bp_hi, bp_lo, lat, busy};
    endfunction

    task automatic send_op(input logic [7:0] code, input sef_op_t k);
        exp_op.push_back(k);
        sef_spi_master_inst.xfer(8, code, junk);
    endtask

    task automatic read_status(input logic [7:0] exp);
        sef_spi_master_inst.sel();
        send_op(8'h05, SEF_OP_SRD);
        repeat (2)
        begin
            sef_spi_master_inst.xfer(8, 8'h00, d);
            cmp_word({1'b0, d}, {1'b0, exp});
        end
        cmp_bit(so_oe_n, 1'b0);
        sef_spi_master_inst.desel();
        cmp_bit(so_oe_n, 1'b1);
    endtask

    task automatic wen();
        sef_spi_master_inst.sel();
        send_op(8'h06, SEF_OP_WEN);
        sef_spi_master_inst.desel();
    endtask

    // Protect pin pulled low mid-selection must cancel the commit
    task automatic do_write(input logic [7:0] code, input sef_op_t k,
                            input int n, input logic glitch);
        wen();
        sef_spi_master_inst.sel();
        send_op(code, k);
        if (k == SEF_OP_AWR)
        begin
            d = 8'($random(seed));
            exp_addr.push_back({code[3], d});
            sef_spi_master_inst.xfer(8, d, junk);
        end
        wp_n = !glitch;
        for (int i = 0; i < n; i++)
        begin
            d = 8'($random(seed));
            exp_rx.push_back(d);
            sef_spi_master_inst.xfer(8, d, junk);
        end
        wp_n = 1'b1;
        if (!glitch)
            exp_ws++;
        sef_spi_master_inst.desel();
    endtask

    initial
    begin
        sef_spi_master_inst.tick(60000);
        num_errors++;
        tally_and_finish();
    end

    initial
    begin
        reset = 1'b1;
        hold_n = 1'b1;
        wp_n = 1'b1;
        write_busy = 1'b0;
        write_done = 1'b0;
        {bp_hi, bp_lo} = 2'($random(seed));
        rd_data = 8'h00;
        sef_spi_master_inst.tick(10);
        reset = 1'b0;
        sef_spi_master_inst.tick(4);
        cmp_bit(so_oe_n, 1'b1);
        cmp_bit(latch, 1'b0);
        cmp_bit(hold_active, 1'b0);
        // Power-up wait of 100 us before the first instruction
        sef_spi_master_inst.tick(20000);
        for (int m = 0; m < 2; m++)
        begin
            sef_spi_master_inst.mode3 = m[0];
            read_status(st(1'b0, 1'b0));
        end
        sef_spi_master_inst.mode3 = 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            wp_n = WTAB[i];
            sef_spi_master_inst.sel();
            send_op(CTAB[i], CTAB[i][1] ? SEF_OP_WEN : SEF_OP_WDI);
            sef_spi_master_inst.xfer(8, 8'hA5, junk);
            sef_spi_master_inst.desel();
            cmp_bit(latch, CTAB[i][1] & WTAB[i]);
        end
        // Random protect level, busy and end-of-write around a write enable
        for (int i = 0; i < 4; i++)
        begin
            r = 3'($random(seed));
            wp_n = r[0];
            write_busy = r[1];
            sef_spi_master_inst.sel();
            send_op(8'h06, SEF_OP_WEN);
            sef_spi_master_inst.desel();
            write_done = r[2];
            sef_spi_master_inst.tick(1);
            write_done = 1'b0;
            write_busy = 1'b0;
            lat = (lat | (r[0] & ~r[1])) & ~r[2];
            sef_spi_master_inst.tick(4);
            cmp_bit(latch, lat);
        end
        sef_spi_master_inst.sel();
        send_op(8'h04, SEF_OP_WDI);
        sef_spi_master_inst.desel();
        wp_n = 1'b1;
        sef_spi_master_inst.sel();
        sef_spi_master_inst.xfer(3, 8'hE0, junk);
        sef_spi_master_inst.desel();
        sef_spi_master_inst.sel();
        sef_spi_master_inst.desel();
        read_status(st(1'b0, 1'b0));
        foreach (BAD[i])
        begin
            sef_spi_master_inst.sel();
            sef_spi_master_inst.xfer(8, BAD[i], junk);
            sef_spi_master_inst.xfer(8, 8'h05, junk);
            cmp_bit(so_oe_n, 1'b1);
            sef_spi_master_inst.desel();
        end
        sef_spi_master_inst.sel();
        exp_op.push_back(SEF_OP_SRD);
        sef_spi_master_inst.xfer(4, 8'h00, junk);
        hold_n = 1'b0;
        sef_spi_master_inst.tick(6);
        cmp_bit(hold_active, 1'b1);
        sef_spi_master_inst.xfer(2, 8'hFF, junk);
        cmp_bit(so_oe_n, 1'b1);
        hold_n = 1'b1;
        sef_spi_master_inst.tick(6);
        cmp_bit(hold_active, 1'b0);
        sef_spi_master_inst.xfer(4, 8'h50, junk);
        sef_spi_master_inst.xfer(8, 8'h00, d);
        cmp_word({1'b0, d}, {1'b0, st(1'b0, 1'b0)});
        sef_spi_master_inst.desel();
        wen();
        sef_spi_master_inst.sel();
        send_op(8'h02, SEF_OP_AWR);
        hold_n = 1'b0;
        sef_spi_master_inst.desel();
        hold_n = 1'b1;
        cmp_bit(latch, 1'b0);
        cmp_word(9'(aborts), 9'h001);
        do_write(8'h0A, SEF_OP_AWR, 2, 1'b1);
        do_write(8'h02, SEF_OP_AWR, 2, 1'b0);
        do_write(8'h09, SEF_OP_SWR, 1, 1'b0);
        write_busy = 1'b1;
        read_status(st(1'b1, 1'b1));
        write_done = 1'b1;
        sef_spi_master_inst.tick(1);
        write_done = 1'b0;
        write_busy = 1'b0;
        sef_spi_master_inst.tick(4);
        cmp_bit(latch, 1'b0);
        // Deselect in hold while a cycle runs must not abort it
        write_busy = 1'b1;
        sef_spi_master_inst.sel();
        send_op(8'h05, SEF_OP_SRD);
        hold_n = 1'b0;
        sef_spi_master_inst.desel();
        hold_n = 1'b1;
        write_busy = 1'b0;
        cmp_word(9'(aborts), 9'h001);
        rd_data = 8'($random(seed));
        sef_spi_master_inst.sel();
        send_op(8'h0B, SEF_OP_ARD);
        exp_addr.push_back(9'h155);
        sef_spi_master_inst.xfer(8, 8'h55, junk);
        sef_spi_master_inst.xfer(8, 8'h00, d);
        cmp_word({1'b0, d}, {1'b0, rd_data});
        sef_spi_master_inst.desel();
        cmp_word(9'(exp_op.size() + exp_addr.size()), 9'h000);
        cmp_word(9'(exp_rx.size()), 9'h000);
        cmp_word(9'(rd_nexts), 9'h001);
        cmp_word(9'(exp_ws), 9'h000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
